// ===== verilog/hpm_pkg.sv
package hpm_pkg;
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned DELAY_US_DFLT   = 1000;
  localparam int unsigned US_CYCLES       = CLK_HZ / 1000000;
  localparam logic [15:0] DELAY_CYC_DFLT  = 16'(DELAY_US_DFLT * US_CYCLES);
  localparam logic [31:0] POS_TOL_DFLT    = 32'h00000001;
  localparam logic [31:0] VEL_TOL_DFLT    = 32'h00000000;
  localparam logic        VEL_MON_DFLT    = 1'b0;
  localparam logic        MANUAL_DFLT     = 1'b0;
  localparam logic        REACT_RAMP_DFLT = 1'b0;
  localparam logic [2:0]  CS_FAILED       = 3'h5;
  localparam logic [2:0]  CS_IDLE         = 3'h0;
  localparam logic [2:0]  CS_STOPPING     = 3'h1;
  localparam logic [2:0]  CS_HOLD         = 3'h2;

  typedef enum logic [3:0] {
    HPM_IDLE  = 4'h1,
    HPM_DELAY = 4'h2,
    HPM_MON   = 4'h4,
    HPM_WAIT  = 4'h8
  } hpm_state_type;

  typedef struct packed {
    logic        vel_mon_en;
    logic        manual_restart;
    logic [31:0] pos_tol;
    logic [31:0] vel_tol;
    logic [15:0] delay_cyc;
  } hpm_cfg_type;

  typedef struct packed {
    logic in_en;
    logic bus_en;
    logic in_req;
    logic bus_req;
    logic stop_req;
  } hpm_act_type;
endpackage

// ===== verilog/hpm_sync.sv
`timescale 1ns/1ps
module hpm_sync
  import hpm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } hpm_sync_st_type;
  hpm_sync_st_type st;
  hpm_sync_st_type next_st;

  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule

// ===== verilog/hpm_vel.sv
`timescale 1ns/1ps
module hpm_vel
  import hpm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] pos,
  output logic [31:0]      vel
);
  typedef struct packed {
    logic [31:0] last;
    logic [31:0] vel;
    logic        primed;
  } hpm_vel_st_type;
  hpm_vel_st_type st;
  hpm_vel_st_type next_st;

  // Velocity as position difference per clock
  always_comb begin
    next_st = st;
    next_st.last = pos;
    next_st.primed = 1'b1;
    next_st.vel = st.primed ? (pos - st.last) : 32'h00000000;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign vel = st.vel;
endmodule

// ===== verilog/hpm_monitor.sv
`timescale 1ns/1ps
module hpm_monitor
  import hpm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire hpm_cfg_type cfg,
  input  wire logic        in_en,
  input  wire logic        bus_en,
  input  wire logic        safe_in_act,
  input  wire logic        bus_act,
  input  wire logic        ack_in_en,
  input  wire logic        ack_bus_en,
  input  wire logic        safe_in_ack,
  input  wire logic        bus_ack,
  input  wire logic        stop_req,
  input  wire logic        stop_react_ramp,
  input  wire logic        limit_fault,
  input  wire logic [31:0] safe_pos,
  output logic             hold_active_flag,
  output logic             fault_activate,
  output logic             hold_restart_req,
  output logic             stop_function_active_flag,
  output logic [2:0]       stop_function_internal_state,
  output logic             stop_torque_disable,
  output logic             stop_ramp_request,
  output logic [31:0]      safe_vel
);
  // One monitor per axis; a multi-axis device instantiates this once per axis
  typedef struct packed {
    hpm_state_type st;
    logic [15:0]   cnt;
    logic [31:0]   hold_pos;
    logic          fault;
    logic          from_stop;
    logic [2:0]    cs_state;
    logic          cs_fault;
    logic          cs_ramp;
  } hpm_st_type;
  hpm_st_type s;
  hpm_st_type next_s;

  logic        in_act_s;
  logic        ack_in_s;
  logic [31:0] vel;
  logic        req;
  logic        ack;
  logic [31:0] dpos;
  logic [31:0] avel;
  logic        pos_bad;
  logic        vel_bad;
  logic        vel_low;

  hpm_sync u_sync_act (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (safe_in_act),
    .dout    (in_act_s)
  );
  hpm_sync u_sync_ack (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (safe_in_ack),
    .dout    (ack_in_s)
  );
  hpm_vel u_vel (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pos     (safe_pos),
    .vel     (vel)
  );

  always_comb begin
    req     = (in_en && in_act_s) || (bus_en && bus_act) || (s.cs_state == CS_HOLD);
    ack     = (ack_in_en && ack_in_s) || (ack_bus_en && bus_ack);
    dpos    = $signed(safe_pos) >= $signed(s.hold_pos) ? safe_pos - s.hold_pos : s.hold_pos - safe_pos;
    avel    = vel[31] ? 32'h00000000 - vel : vel;
    pos_bad = dpos > cfg.pos_tol;
    vel_bad = cfg.vel_mon_en && (avel > cfg.vel_tol);
    vel_low = avel < cfg.vel_tol;
  end

  always_comb begin
    next_s = s;
    // Controlled stop tail: stopping until velocity drops, then hold
    case (s.cs_state)
      CS_IDLE: begin
        if (stop_req || limit_fault) begin
          next_s.cs_state = CS_STOPPING;
        end
      end
      CS_STOPPING: begin
        if (vel_low) begin
          next_s.cs_state = CS_HOLD;
        end else if (!stop_req && !limit_fault) begin
          next_s.cs_state = CS_IDLE;
        end
      end
      CS_HOLD: begin
        if (!stop_req && !limit_fault) begin
          next_s.cs_state = CS_IDLE;
        end
      end
      default: begin
        next_s.cs_state = CS_FAILED;
      end
    endcase
    // Fault on the held axis while the stop owns it, or zero tolerance stalls handover
    if (s.cs_state != CS_IDLE && s.cs_state != CS_FAILED && (s.fault || cfg.vel_tol == 32'h00000000)) begin
      next_s.cs_state = CS_FAILED;
      next_s.cs_fault = 1'b1;
      next_s.cs_ramp  = stop_react_ramp;
    end

    case (s.st)
      HPM_IDLE: begin
        if (req) begin
          next_s.hold_pos  = safe_pos;
          next_s.from_stop = (s.cs_state == CS_HOLD);
          next_s.cnt       = 16'h0000;
          next_s.st        = (s.cs_state == CS_HOLD) ? HPM_MON : HPM_DELAY;
        end
      end
      HPM_DELAY: begin
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt + 16'h0001 >= cfg.delay_cyc) begin
          next_s.hold_pos = safe_pos;
          next_s.st       = HPM_MON;
        end
        if (!req) begin
          next_s.st = cfg.manual_restart ? HPM_WAIT : HPM_IDLE;
        end
      end
      HPM_MON: begin
        if (pos_bad || vel_bad) begin
          next_s.fault = 1'b1;
        end
        if (!req) begin
          next_s.st = cfg.manual_restart ? HPM_WAIT : HPM_IDLE;
        end
      end
      HPM_WAIT: begin
        if (pos_bad || vel_bad) begin
          next_s.fault = 1'b1;
        end
        if (req) begin
          next_s.st = HPM_MON;
        end else if (ack) begin
          next_s.st = HPM_IDLE;
        end
      end
      default: begin
        next_s.st = HPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s.st        <= HPM_IDLE;
      s.cnt       <= 16'h0000;
      s.hold_pos  <= 32'h00000000;
      s.fault     <= 1'b0;
      s.from_stop <= 1'b0;
      s.cs_state  <= CS_IDLE;
      s.cs_fault  <= 1'b0;
      s.cs_ramp   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign hold_active_flag             = (s.st != HPM_IDLE);
  assign fault_activate               = s.fault;
  assign hold_restart_req             = (s.st == HPM_WAIT) && !req;
  assign stop_function_active_flag    = (s.cs_state != CS_IDLE);
  assign stop_function_internal_state = s.cs_state;
  assign stop_torque_disable          = s.cs_fault && !s.cs_ramp;
  assign stop_ramp_request            = s.cs_fault && s.cs_ramp;
  assign safe_vel                     = vel;

  cover_hold_c: cover property (@(posedge ref_clk) disable iff (rst) s.st == HPM_MON);
  cover_fault_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(s.fault));
  cover_wait_c: cover property (@(posedge ref_clk) disable iff (rst) s.st == HPM_WAIT ##1 s.st == HPM_IDLE);
  cover_csfail_c: cover property (@(posedge ref_clk) disable iff (rst) s.cs_state == CS_FAILED);

  pos_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_MON && pos_bad) |=> fault_activate)
    else $error("position violation did not raise fault");
  vel_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_MON && cfg.vel_mon_en && avel > cfg.vel_tol) |=> fault_activate)
    else $error("velocity violation did not raise fault");
  hold_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_IDLE && req) |=> s.hold_pos == $past(safe_pos))
    else $error("hold position not captured");
  stop_skip_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_IDLE && s.cs_state == CS_HOLD) |=> s.st == HPM_MON)
    else $error("stop activation did not skip delay");
  delay_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_DELAY && s.cnt + 16'h0001 < cfg.delay_cyc && req) |=> s.st == HPM_DELAY)
    else $error("delay ended early");
  auto_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_MON && !req && !cfg.manual_restart) |=> s.st == HPM_IDLE)
    else $error("automatic restart did not deactivate");
  manual_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_WAIT && !ack && !req) |=> hold_active_flag && s.st == HPM_WAIT)
    else $error("manual restart released without acknowledge");

  restart_req_a: assert property (@(posedge ref_clk) disable iff (rst)
    hold_restart_req |-> s.st == HPM_WAIT)
    else $error("restart request outside wait state");

  fault_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    fault_activate |=> fault_activate)
    else $error("fault output dropped");

  idle_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_IDLE) |-> !hold_active_flag)
    else $error("active flag while idle");

  delay_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == HPM_DELAY && req && s.cnt + 16'h0001 >= cfg.delay_cyc) |=> s.st == HPM_MON)
    else $error("delay did not end on time");

  cs_handover_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.cs_state == CS_STOPPING && vel_low && !s.fault && cfg.vel_tol != 32'h00000000)
      |=> s.cs_state == CS_HOLD)
    else $error("stop did not hand over to hold");

  zero_tol_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.cs_state == CS_STOPPING && cfg.vel_tol == 32'h00000000) |=> s.cs_state == CS_FAILED)
    else $error("zero tolerance did not fail the stop");

  cs_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.cs_state == CS_FAILED) |=> s.cs_state == CS_FAILED)
    else $error("failed stop left its failed state");

  stop_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.cs_state == CS_IDLE && stop_req) |=> stop_function_active_flag)
    else $error("stop request did not raise stop flag");
  cs_failed_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s.cs_fault) |-> stop_function_internal_state == CS_FAILED)
    else $error("stop failure state not five");
  cs_react_a: assert property (@(posedge ref_clk) disable iff (rst)
    s.cs_fault |-> (stop_torque_disable != stop_ramp_request))
    else $error("stop fault reaction not exclusive");
endmodule

// ===== verification/hpm_ctrl_model.sv
`timescale 1ns/1ps
module hpm_ctrl_model (
  input  wire logic ref_clk,
  input  wire logic hold_restart_req,
  input  wire logic use_input,
  input  wire integer ack_wait,
  output logic      bus_ack,
  output logic      safe_in_ack
);
  int cnt = 0;
  initial begin
    bus_ack = 1'b0;
    safe_in_ack = 1'b0;
    forever begin
      @(negedge ref_clk);
      cnt = hold_restart_req ? cnt + 1 : 0;
      // Acknowledge only once the monitor asks, after a chosen wait
      bus_ack <= hold_restart_req && !use_input && cnt > ack_wait;
      safe_in_ack <= hold_restart_req && use_input && cnt > ack_wait;
    end
  end
endmodule

// ===== verification/standstill_position_monitor_tb.sv
`timescale 1ns/1ps
module standstill_position_monitor_tb;
  import hpm_pkg::*;
  localparam int TOL = 4;
  logic        ref_clk, rst, in_en, bus_en, safe_in_act, bus_act, ack_in_en, ack_bus_en;
  logic        safe_in_ack, bus_ack, stop_req, stop_react_ramp, limit_fault, use_input;
  logic        hold_active_flag, fault_activate, hold_restart_req, stop_function_active_flag;
  logic        stop_torque_disable, stop_ramp_request;
  logic [2:0]  stop_function_internal_state;
  logic [31:0] safe_pos, safe_vel;
  hpm_cfg_type cfg;
  int          ack_wait, miscompares, checks, cycles, cap, off;
  logic        exp_fault;

  hpm_monitor i_hpm_monitor (.ref_clk, .rst, .cfg, .in_en, .bus_en, .safe_in_act, .bus_act,
    .ack_in_en, .ack_bus_en, .safe_in_ack, .bus_ack, .stop_req, .stop_react_ramp, .limit_fault,
    .safe_pos, .hold_active_flag, .fault_activate, .hold_restart_req, .stop_function_active_flag,
    .stop_function_internal_state, .stop_torque_disable, .stop_ramp_request, .safe_vel);
  hpm_ctrl_model i_hpm_ctrl_model (.ref_clk, .hold_restart_req, .use_input, .ack_wait, .bus_ack,
    .safe_in_ack);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Reset with a fresh configuration and a random resting position
  task automatic setup(logic vm, logic man, int vt, int dly);
    rst = 1'b1;
    {in_en, bus_en, safe_in_act, bus_act, ack_in_en, ack_bus_en} = '0;
    {stop_req, stop_react_ramp, limit_fault, use_input} = '0;
    cfg = '{vel_mon_en: vm, manual_restart: man, pos_tol: 32'(TOL), vel_tol: 32'(vt), delay_cyc: 16'(dly)};
    cap = int'($urandom_range(1000, 100000));
    safe_pos = 32'(cap);
    exp_fault = 1'b0;
    cyc(10);
    rst = 1'b0;
    cyc(1);
  endtask

  function automatic logic outside(int p);
    return (p - cap > TOL) || (cap - p > TOL);
  endfunction

  initial begin
    void'($urandom(32'hD3A0));
    ack_wait = 0;
    setup(1'b0, 1'b0, 0, 5);
    check("fault at reset", fault_activate, 1'b0);
    bus_en = 1'b1;
    bus_act = 1'b1;
    cyc(1);
    check("active", hold_active_flag, 1'b1);
    cap = cap + 100;
    safe_pos = 32'(cap);
    cyc(8);
    check("fault in delay", fault_activate, 1'b0);
    for (int i = 0; i < 8; i++) begin
      off = (i == 7) ? -TOL - 1 : int'($urandom_range(0, 2 * TOL + 2)) - TOL - 1;
      safe_pos = 32'(cap + off);
      exp_fault |= outside(cap + off);
      cyc(2);
      check("window fault", fault_activate, exp_fault);
    end
    $display("test window done");

    setup(1'b0, 1'b0, 0, 5);
    bus_en = 1'b1;
    bus_act = 1'b1;
    cyc(3);
    bus_act = 1'b0;
    cyc(2);
    check("auto release", hold_active_flag, 1'b0);
    check("auto no request", hold_restart_req, 1'b0);
    $display("test auto restart done");

    for (int s = 0; s < 2; s++) begin
      setup(1'b0, 1'b1, 0, 5);
      {in_en, bus_en, ack_in_en, ack_bus_en} = 4'hF;
      use_input = (s == 0);
      ack_wait = 4;
      if (s) safe_in_act = 1'b1;
      else bus_act = 1'b1;
      cyc(4);
      check("active", hold_active_flag, 1'b1);
      {safe_in_act, bus_act} = 2'b00;
      cyc(4);
      check("held", hold_active_flag, 1'b1);
      check("request", hold_restart_req, 1'b1);
      cyc(12);
      check("released", hold_active_flag, 1'b0);
      check("request gone", hold_restart_req, 1'b0);
    end
    $display("test manual restart done");

    setup(1'b1, 1'b0, 3, 0);
    bus_en = 1'b1;
    bus_act = 1'b1;
    for (int i = 0; i < 12; i++) begin
      safe_pos = 32'(cap + ((i >= 8) ? 6 : (i % 2) * 2));
      cyc(1);
      if (i == 7) check("velocity", safe_vel, 32'h00000002);
      if (i == 7) check("slow ok", fault_activate, 1'b0);
    end
    check("fast fault", fault_activate, 1'b1);
    $display("test velocity done");

    setup(1'b0, 1'b0, 3, 60);
    stop_req = 1'b1;
    cyc(4);
    check("stop state", stop_function_internal_state, CS_HOLD);
    check("stop flag", stop_function_active_flag, 1'b1);
    check("hold engaged", hold_active_flag, 1'b1);
    safe_pos = 32'(cap + TOL + 1);
    cyc(3);
    check("no delay", fault_activate, 1'b1);
    $display("test controlled stop done");

    for (int r = 0; r < 2; r++) begin
      setup(1'b0, 1'b0, 0, 5);
      stop_react_ramp = r[0];
      if (r) limit_fault = 1'b1;
      else stop_req = 1'b1;
      cyc(4);
      check("failed state", stop_function_internal_state, CS_FAILED);
      check("torque off", stop_torque_disable, !r[0]);
      check("ramp stop", stop_ramp_request, r[0]);
    end
    $display("test stop failure done");
    conclude();
  end
endmodule
